// ===== hdl/fsp_device.sv
// self-programming sequencer: control register, timed windows, page buffer,
// erase/write/lock operations, lock and fuse reads
// assumes a flash macro that reads the buffer while flash_start is acted on
`timescale 1ns/10ps

// Function
// - erase armed, store within four cycles
// - erase keeps other region readable or halts
// - fill stores data pair at word field
// - buffer cleared on write, reenable, reset
// - each buffer word loads once only
// - eeprom write discards loaded buffer
// - write armed, store within four, low bits zero
// - write keeps other region readable or halts
// - ready interrupt while arm bit clear
// - region busy flag blocks region reads
// - software reenables region after programming
// - software keeps interrupts off around sequence
// - lock set, zero bits program locks
// - lock byte layout, flash stays readable
// - software uses pointer one, top bits set
// - eeprom busy refuses programming and reads
// - software checks eeprom busy first
// - lock read, load within three cycles
// - arm and lock-access auto clear
// - pointer selects fuse byte on read
// - programmed reads zero, unprogrammed one
// - timed operation survives core reset
module fsp_device
	import fsp_pkg::*;
#(
	parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF // operation length
)(
	input  wire logic              aclk,               // core clock
	input  wire logic              aresetn,            // sync core reset, low
	input  wire logic              por_n,              // sync power-on reset, low
	fsp_if.dev                     cpu,                // core side
	input  wire logic [7:0]        fuse_low_byte,      // stored low fuses
	input  wire logic [7:0]        fuse_high_byte,     // stored high fuses
	input  wire logic [7:0]        extended_fuse_byte, // stored extended fuses
	input  wire logic              eeprom_write_busy,  // eeprom write running
	input  wire logic [WORD_W-1:0] buf_rd_idx,         // flash macro buffer index
	output logic      [15:0]       buf_rd_word,        // buffer word to macro
	output logic                   flash_start,        // operation start pulse
	output logic                   flash_erase,        // 1 erase, 0 write
	output logic      [PAGE_W-1:0] flash_page,         // page under operation
	output logic                   rww_read_block,     // region reads refused
	output logic                   selfprog_irq,       // ready interrupt
	output logic      [LOCK_W-1:0] lock_bits           // lock bits, 0 programmed
);
	// ------------------------------------------------------------
	// control group state
	// ------------------------------------------------------------
	fsp_ctl_state_t   state_ff, nxt_state;
	logic [SEL_W-1:0] sel_ff, nxt_sel;
	logic [2:0]       win_ff, nxt_win;
	logic             ien_ff, nxt_ien;
	logic             rww_busy_ff, nxt_rww_busy;
	logic             lpm_valid_ff, nxt_lpm_valid;
	logic [7:0]       lpm_data_ff, nxt_lpm_data;

	// operation group state, kept across core reset
	logic              op_run_ff, nxt_op_run;
	logic [2:0]        op_kind_ff, nxt_op_kind;  // {lock, write, erase}
	logic [PAGE_W-1:0] op_arg_ff, nxt_op_arg;
	logic [TMR_W-1:0]  tmr_ff, nxt_tmr;
	logic [LOCK_W-1:0] lock_ff, nxt_lock;
	logic              start_ff, nxt_start;

	logic [4:0] cmd;
	logic       ctl_take, spm_take, lpm_take, op_ok, op_done;
	logic       buf_clear, buf_load, arm_shown;

	// decode of requests
	assign cmd       = {sel_ff, 1'b1};
	assign ctl_take  = cpu.ctl_wr && !eeprom_write_busy && !op_run_ff;
	assign spm_take  = cpu.spm && state_ff == C_ARMED && win_ff != 3'h0 && !eeprom_write_busy;
	assign lpm_take  = cpu.lpm && state_ff == C_ARMED && cmd == CMD_LOCK && !eeprom_write_busy
		&& win_ff > (WIN_SPM - WIN_LPM);
	assign op_ok     = (cmd == CMD_ERASE) || (cmd == CMD_LOCK)
		|| (cmd == CMD_WRITE && cpu.zptr[PAGE_LSB-1:0] == '0);
	assign op_done   = op_run_ff && tmr_ff == '0;
	assign buf_load  = spm_take && cmd == CMD_FILL;
	assign buf_clear = (op_done && op_kind_ff[1])
		|| (ctl_take && cpu.ctl_wdata[B_REEN])
		|| eeprom_write_busy;

	// ------------------------------------------------------------
	// control group next values
	// ------------------------------------------------------------
	always_comb
	begin
		nxt_state     = state_ff;
		nxt_sel       = sel_ff;
		nxt_win       = win_ff;
		nxt_ien       = ien_ff;
		nxt_rww_busy  = rww_busy_ff;
		nxt_lpm_valid = 1'b0;
		nxt_lpm_data  = lpm_data_ff;
		if (cpu.ctl_wr && !eeprom_write_busy)
			nxt_ien = cpu.ctl_wdata[B_IEN];
		case (state_ff)
			C_IDLE, C_ARMED:
			begin
				if (win_ff != 3'h0)
					nxt_win = win_ff - 3'h1;
				if (ctl_take)
				begin
					nxt_state = cpu.ctl_wdata[B_ARM] ? C_ARMED : C_IDLE;
					nxt_sel   = cpu.ctl_wdata[B_ARM] ? cpu.ctl_wdata[SEL_LSB +: SEL_W] : '0;
					nxt_win   = WIN_SPM;
				end
				else if (spm_take)
				begin
					nxt_state = (op_ok && cmd != CMD_FILL && cmd != CMD_REEN) ? C_WAIT : C_IDLE;
					if (nxt_state == C_IDLE)
						nxt_sel = '0;
					if (cmd == CMD_REEN)
						nxt_rww_busy = 1'b0;
					if (cmd == CMD_ERASE || (cmd == CMD_WRITE && op_ok))
						nxt_rww_busy = 1'b1;
				end
				else if (lpm_take)
				begin
					nxt_state     = C_IDLE;
					nxt_sel       = '0;
					nxt_lpm_valid = 1'b1;
					case (cpu.zptr)
						Z_LOCK:      nxt_lpm_data = {LOCK_PAD, lock_ff};
						Z_FUSE_LOW:  nxt_lpm_data = fuse_low_byte;
						Z_FUSE_HIGH: nxt_lpm_data = fuse_high_byte;
						Z_FUSE_EXT:  nxt_lpm_data = extended_fuse_byte;
						default:     nxt_lpm_data = NO_BYTE;
					endcase
				end
				else if (state_ff == C_ARMED && win_ff <= 3'h1)
				begin
					nxt_state = C_IDLE;
					nxt_sel   = '0;
				end
			end
			C_WAIT:
			begin
				if (op_done || !op_run_ff)
				begin
					nxt_state = C_IDLE;
					nxt_sel   = '0;
				end
			end
			default:
			begin
				nxt_state = C_IDLE;
				nxt_sel   = '0;
			end
		endcase
	end

	// register the control group
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_ff     <= C_IDLE;
			sel_ff       <= '0;
			win_ff       <= '0;
			ien_ff       <= 1'b0;
			rww_busy_ff  <= 1'b0;
			lpm_valid_ff <= 1'b0;
			lpm_data_ff  <= '0;
		end
		else
		begin
			state_ff     <= nxt_state;
			sel_ff       <= nxt_sel;
			win_ff       <= nxt_win;
			ien_ff       <= nxt_ien;
			rww_busy_ff  <= nxt_rww_busy;
			lpm_valid_ff <= nxt_lpm_valid;
			lpm_data_ff  <= nxt_lpm_data;
		end
	end

	// ------------------------------------------------------------
	// operation group next values
	// ------------------------------------------------------------
	always_comb
	begin
		nxt_op_run  = op_run_ff;
		nxt_op_kind = op_kind_ff;
		nxt_op_arg  = op_arg_ff;
		nxt_tmr     = tmr_ff;
		nxt_lock    = lock_ff;
		nxt_start   = 1'b0;
		if (op_run_ff)
		begin
			nxt_tmr = tmr_ff - TMR_W'(1);
			if (op_done)
			begin
				nxt_op_run = 1'b0;
				if (op_kind_ff[2])
					nxt_lock = lock_ff & op_arg_ff[LOCK_W-1:0];
			end
		end
		else if (spm_take && op_ok && cmd != CMD_FILL && cmd != CMD_REEN)
		begin
			nxt_op_run  = 1'b1;
			nxt_tmr     = TMR_W'(PROG_CYCLES - 1);
			nxt_op_kind = {cmd == CMD_LOCK, cmd == CMD_WRITE, cmd == CMD_ERASE};
			nxt_op_arg  = (cmd == CMD_LOCK) ? PAGE_W'(cpu.wdata[LOCK_W-1:0])
				: cpu.zptr[PAGE_LSB +: PAGE_W];
			nxt_start   = cmd != CMD_LOCK;
		end
	end

	// register the operation group, only power-on reset stops it
	always_ff @(posedge aclk)
	begin
		if (!por_n)
		begin
			op_run_ff  <= 1'b0;
			op_kind_ff <= '0;
			op_arg_ff  <= '0;
			tmr_ff     <= '0;
			lock_ff    <= LOCK_ERASED;
			start_ff   <= 1'b0;
		end
		else
		begin
			op_run_ff  <= nxt_op_run;
			op_kind_ff <= nxt_op_kind;
			op_arg_ff  <= nxt_op_arg;
			tmr_ff     <= nxt_tmr;
			lock_ff    <= nxt_lock;
			start_ff   <= nxt_start;
		end
	end

	// page buffer
	fsp_page_buffer u_buf (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.clear     (buf_clear),
		.load      (buf_load && !eeprom_write_busy),
		.load_idx  (cpu.zptr[WORD_LSB +: WORD_W]),
		.load_word (cpu.wdata),
		.rd_idx    (buf_rd_idx),
		.rd_word   (buf_rd_word)
	);

	// outputs
	assign arm_shown      = state_ff != C_IDLE || op_run_ff;
	assign cpu.ctl_rdata  = {ien_ff, rww_busy_ff, 1'b0, sel_ff, arm_shown};
	assign cpu.lpm_valid  = lpm_valid_ff;
	assign cpu.lpm_data   = lpm_data_ff;
	assign cpu.ee_busy    = eeprom_write_busy;
	assign cpu.cpu_halt   = op_run_ff && !op_kind_ff[2]
		&& op_arg_ff >= NON_READABLE_REGION_PAGE;
	assign rww_read_block = rww_busy_ff
		|| (op_run_ff && !op_kind_ff[2]);
	assign selfprog_irq   = ien_ff && !arm_shown;
	assign flash_start    = start_ff;
	assign flash_erase    = op_kind_ff[0];
	assign flash_page     = op_arg_ff;
	assign lock_bits      = lock_ff;
endmodule : fsp_device

// ===== hdl/fsp_pkg.sv
// constants, encodings and state types of the self-programming sequencer
// assumes a 100 MHz core clock shared by both ends
package fsp_pkg;
	// ------------------------------------------------------------
	// clock and programming time
	// ------------------------------------------------------------
	localparam int unsigned CLK_MHZ         = 100;
	localparam int unsigned PROG_MIN_US_X10 = 37;   // 3.7 ms, tenths of ms
	localparam int unsigned PROG_MAX_US_X10 = 45;   // 4.5 ms, tenths of ms
	localparam int unsigned PROG_CYCLES_DEF = PROG_MIN_US_X10 * 100 * CLK_MHZ;
	localparam int unsigned TMR_W           = 19;

	// ------------------------------------------------------------
	// control/status bit positions and command patterns
	// ------------------------------------------------------------
	localparam int unsigned B_ARM   = 0;
	localparam int unsigned B_REEN  = 4;
	localparam int unsigned B_BUSY  = 6;
	localparam int unsigned B_IEN   = 7;
	localparam int unsigned SEL_LSB = 1;
	localparam int unsigned SEL_W   = 4;
	localparam logic [4:0] CMD_FILL  = 5'h01;
	localparam logic [4:0] CMD_ERASE = 5'h03;
	localparam logic [4:0] CMD_WRITE = 5'h05;
	localparam logic [4:0] CMD_LOCK  = 5'h09;
	localparam logic [4:0] CMD_REEN  = 5'h11;
	localparam logic [2:0] WIN_SPM   = 3'h4;
	localparam logic [2:0] WIN_LPM   = 3'h3;

	// ------------------------------------------------------------
	// pointer fields, regions, lock and fuse reads
	// ------------------------------------------------------------
	localparam int unsigned PAGE_LSB = 7;
	localparam int unsigned PAGE_W   = 7;
	localparam int unsigned WORD_LSB = 1;
	localparam int unsigned WORD_W   = 6;
	localparam int unsigned WORDS    = 64;
	localparam logic [PAGE_W-1:0] NON_READABLE_REGION_PAGE   = 7'h70;
	localparam logic [15:0]       Z_FUSE_LOW  = 16'h0000;
	localparam logic [15:0]       Z_LOCK      = 16'h0001;
	localparam logic [15:0]       Z_FUSE_EXT  = 16'h0002;
	localparam logic [15:0]       Z_FUSE_HIGH = 16'h0003;
	localparam int unsigned       LOCK_W      = 6;
	localparam logic [LOCK_W-1:0] LOCK_ERASED = 6'h3F;
	localparam logic [1:0]        LOCK_PAD    = 2'h3;
	localparam logic [7:0]        NO_BYTE     = 8'hFF;
	localparam logic [15:0]       ERASED_WORD = 16'hFFFF;

	// host register map (byte offsets) and bus answers
	localparam logic [3:0] REG_ZPTR   = 4'h0;
	localparam logic [3:0] REG_DATA   = 4'h4;
	localparam logic [3:0] REG_CMD    = 4'h8;
	localparam logic [3:0] REG_STAT   = 4'hC;
	localparam int unsigned FOLLOW_LSB = 8;
	localparam logic [1:0] FOLLOW_SPM  = 2'h1;
	localparam logic [1:0] FOLLOW_LPM  = 2'h2;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {C_IDLE, C_ARMED, C_WAIT} fsp_ctl_state_t;
	typedef enum logic [2:0] {H_IDLE, H_WAIT, H_CTRL, H_INSTR, H_READ} fsp_host_state_t;
endpackage : fsp_pkg

// ===== hdl/fsp_if.sv
// link between the cpu core end and the self-programming sequencer
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface fsp_if;
	logic        ctl_wr;     // control register write strobe
	logic [7:0]  ctl_wdata;  // control register write value
	logic [7:0]  ctl_rdata;  // control/status readback
	logic        spm;        // store-program instruction strobe
	logic        lpm;        // load-program instruction strobe
	logic [15:0] zptr;       // address pointer
	logic [15:0] wdata;      // data register pair, high:low
	logic        lpm_valid;  // lock/fuse byte answer
	logic [7:0]  lpm_data;   // lock/fuse byte
	logic        ee_busy;    // eeprom write in progress
	logic        cpu_halt;   // core stalled

	modport dev (input ctl_wr, ctl_wdata, spm, lpm, zptr, wdata,
		output ctl_rdata, lpm_valid, lpm_data, ee_busy, cpu_halt);
	modport cpu (output ctl_wr, ctl_wdata, spm, lpm, zptr, wdata,
		input ctl_rdata, lpm_valid, lpm_data, ee_busy, cpu_halt);
endinterface : fsp_if

// ===== hdl/fsp_page_buffer.sv
// temporary page buffer, one word per location, load-once until cleared
// assumes single-cycle loads from the sequencer; clear is held while the eeprom write runs
`timescale 1ns/10ps
module fsp_page_buffer
	import fsp_pkg::*;
(
	input  wire logic              aclk,      // core clock
	input  wire logic              aresetn,   // sync reset, low
	input  wire logic              clear,     // drop every loaded word
	input  wire logic              load,      // store one word
	input  wire logic [WORD_W-1:0] load_idx,  // word in page
	input  wire logic [15:0]       load_word, // word to store
	input  wire logic [WORD_W-1:0] rd_idx,    // readout index
	output logic      [15:0]       rd_word    // readout word
);
	// ------------------------------------------------------------
	// storage, one generate entry per word
	// ------------------------------------------------------------
	logic [15:0] word_ff [WORDS];
	logic        full_ff [WORDS];

	for (genvar i = 0; i < WORDS; i++)
	begin : g_entry
		logic [15:0] nxt_word;
		logic        nxt_full;

		// second load to a filled word is ignored
		always_comb
		begin
			nxt_word = word_ff[i];
			nxt_full = full_ff[i];
			if (clear)
			begin
				nxt_word = ERASED_WORD;
				nxt_full = 1'b0;
			end
			else if (load && load_idx == WORD_W'(i) && !full_ff[i])
			begin
				nxt_word = load_word;
				nxt_full = 1'b1;
			end
		end

		// register the entry, reset empties it
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
			begin
				word_ff[i] <= ERASED_WORD;
				full_ff[i] <= 1'b0;
			end
			else
			begin
				word_ff[i] <= nxt_word;
				full_ff[i] <= nxt_full;
			end
		end
	end

	// readout
	assign rd_word = word_ff[rd_idx];
endmodule : fsp_page_buffer

// ===== hdl/fsp_host.sv
// cpu core end: takes commands over AXI4-Lite and plays the timed sequence
// assumes a single-clock AXI4-Lite master in the same domain
`timescale 1ns/10ps
module fsp_host
	import fsp_pkg::*;
(
	input  wire logic        aclk,          // core clock
	input  wire logic        aresetn,       // sync reset, low
	fsp_if.cpu               dev,           // sequencer side
	input  wire logic        s_axi_awvalid, // write address valid
	output logic             s_axi_awready, // write address ready
	input  wire logic [3:0]  s_axi_awaddr,  // write byte address
	input  wire logic        s_axi_wvalid,  // write data valid
	output logic             s_axi_wready,  // write data ready
	input  wire logic [31:0] s_axi_wdata,   // write data
	input  wire logic [3:0]  s_axi_wstrb,   // byte enables
	output logic             s_axi_bvalid,  // write response valid
	input  wire logic        s_axi_bready,  // write response ready
	output logic      [1:0]  s_axi_bresp,   // write response
	input  wire logic        s_axi_arvalid, // read address valid
	output logic             s_axi_arready, // read address ready
	input  wire logic [3:0]  s_axi_araddr,  // read byte address
	output logic             s_axi_rvalid,  // read data valid
	input  wire logic        s_axi_rready,  // read data ready
	output logic      [31:0] s_axi_rdata,   // read data
	output logic      [1:0]  s_axi_rresp    // read response
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	fsp_host_state_t st_ff, nxt_st;
	logic        aw_ff, nxt_aw, w_ff, nxt_w, b_ff, nxt_b, r_ff, nxt_r;
	logic [3:0]  awa_ff, nxt_awa;
	logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
	logic [3:0]  ws_ff, nxt_ws;
	logic [1:0]  br_ff, nxt_br, rr_ff, nxt_rr;
	logic [15:0] z_ff, nxt_z, d_ff, nxt_d;
	logic [9:0]  cmd_ff, nxt_cmd;
	logic [7:0]  byte_ff, nxt_byte;
	logic        wr_do;

	assign wr_do = aw_ff && w_ff;

	// ------------------------------------------------------------
	// bus and sequence next values
	// ------------------------------------------------------------
	always_comb
	begin
		nxt_st = st_ff; nxt_aw = aw_ff; nxt_w = w_ff; nxt_b = b_ff; nxt_r = r_ff;
		nxt_awa = awa_ff; nxt_wd = wd_ff; nxt_ws = ws_ff; nxt_rd = rd_ff;
		nxt_br = br_ff; nxt_rr = rr_ff; nxt_z = z_ff; nxt_d = d_ff;
		nxt_cmd = cmd_ff; nxt_byte = byte_ff;
		if (s_axi_awvalid && s_axi_awready)
		begin
			nxt_aw  = 1'b1;
			nxt_awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			nxt_w  = 1'b1;
			nxt_wd = s_axi_wdata;
			nxt_ws = s_axi_wstrb;
		end
		if (b_ff && s_axi_bready)
			nxt_b = 1'b0;
		// perform a write once address and data are both held
		if (wr_do)
		begin
			nxt_aw = 1'b0;
			nxt_w  = 1'b0;
			nxt_b  = 1'b1;
			nxt_br = RESP_OKAY;
			case (awa_ff)
				REG_ZPTR:
				begin
					if (ws_ff[0]) nxt_z[7:0]  = wd_ff[7:0];
					if (ws_ff[1]) nxt_z[15:8] = wd_ff[15:8];
				end
				REG_DATA:
				begin
					if (ws_ff[0]) nxt_d[7:0]  = wd_ff[7:0];
					if (ws_ff[1]) nxt_d[15:8] = wd_ff[15:8];
				end
				REG_CMD:
				begin
					if (st_ff == H_IDLE && ws_ff[0])
					begin
						nxt_cmd = wd_ff[9:0];
						nxt_st  = H_WAIT;
					end
				end
				REG_STAT: ;
				default: nxt_br = RESP_SLVERR;
			endcase
		end
		// reads answer one cycle after the address
		if (r_ff && s_axi_rready)
			nxt_r = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			nxt_r  = 1'b1;
			nxt_rr = RESP_OKAY;
			case (s_axi_araddr)
				REG_ZPTR: nxt_rd = {16'h0000, z_ff};
				REG_DATA: nxt_rd = {16'h0000, d_ff};
				REG_CMD:  nxt_rd = {22'h000000, cmd_ff};
				REG_STAT: nxt_rd = {13'h0000, dev.ee_busy, dev.cpu_halt, st_ff != H_IDLE,
					byte_ff, dev.ctl_rdata};
				default:
				begin
					nxt_rd = '0;
					nxt_rr = RESP_SLVERR;
				end
			endcase
		end
		// timed sequence, never broken up once started
		case (st_ff)
			H_IDLE: ;
			H_WAIT: if (!dev.ee_busy && !dev.ctl_rdata[B_ARM] && !dev.cpu_halt)
				nxt_st = H_CTRL;
			H_CTRL: nxt_st = (cmd_ff[FOLLOW_LSB +: 2] == FOLLOW_SPM
				|| cmd_ff[FOLLOW_LSB +: 2] == FOLLOW_LPM) ? H_INSTR : H_IDLE;
			H_INSTR: nxt_st = (cmd_ff[FOLLOW_LSB +: 2] == FOLLOW_LPM) ? H_READ : H_IDLE;
			H_READ:
			begin
				if (dev.lpm_valid)
					nxt_byte = dev.lpm_data;
				nxt_st = H_IDLE;
			end
			default: nxt_st = H_IDLE;
		endcase
	end

	// register everything
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_ff <= H_IDLE; aw_ff <= 1'b0; w_ff <= 1'b0; b_ff <= 1'b0; r_ff <= 1'b0;
			awa_ff <= '0; wd_ff <= '0; ws_ff <= '0; rd_ff <= '0; br_ff <= RESP_OKAY;
			rr_ff <= RESP_OKAY; z_ff <= '0; d_ff <= '0; cmd_ff <= '0; byte_ff <= '0;
		end
		else
		begin
			st_ff <= nxt_st; aw_ff <= nxt_aw; w_ff <= nxt_w; b_ff <= nxt_b; r_ff <= nxt_r;
			awa_ff <= nxt_awa; wd_ff <= nxt_wd; ws_ff <= nxt_ws; rd_ff <= nxt_rd; br_ff <= nxt_br;
			rr_ff <= nxt_rr; z_ff <= nxt_z; d_ff <= nxt_d; cmd_ff <= nxt_cmd; byte_ff <= nxt_byte;
		end
	end

	// outputs
	assign s_axi_awready = !aw_ff && !b_ff;
	assign s_axi_wready  = !w_ff && !b_ff;
	assign s_axi_bvalid  = b_ff;
	assign s_axi_bresp   = br_ff;
	assign s_axi_arready = !r_ff;
	assign s_axi_rvalid  = r_ff;
	assign s_axi_rdata   = rd_ff;
	assign s_axi_rresp   = rr_ff;
	assign dev.ctl_wr    = st_ff == H_CTRL;
	assign dev.ctl_wdata = cmd_ff[7:0];
	assign dev.spm       = st_ff == H_INSTR && cmd_ff[FOLLOW_LSB +: 2] == FOLLOW_SPM;
	assign dev.lpm       = st_ff == H_INSTR && cmd_ff[FOLLOW_LSB +: 2] == FOLLOW_LPM;
	assign dev.zptr      = z_ff;
	assign dev.wdata     = d_ff;
endmodule : fsp_host

// ===== testbench/fsp_checker.sv
// assertions on the core-to-sequencer link
// assumes one clock and a sync low reset
`timescale 1ns/10ps
module fsp_checker
	import fsp_pkg::*;
#(
	parameter int unsigned PROG_CYCLES = 20 // op length
)(
	input wire logic        aclk,      // clock
	input wire logic        aresetn,   // reset
	input wire logic        ctl_wr,    // ctl write
	input wire logic [7:0]  ctl_wdata, // ctl value
	input wire logic [7:0]  ctl_rdata, // status
	input wire logic        spm,       // store
	input wire logic        lpm,       // load
	input wire logic [15:0] zptr,      // pointer
	input wire logic        lpm_valid, // byte ready
	input wire logic        ee_busy,   // eeprom busy
	input wire logic        cpu_halt   // stall
);
	// ----------
	// link rules
	// ----------
	logic [7:0] arm_cnt_ff;
	logic [7:0] nxt_arm_cnt;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// cycles with arm readback high
	always_comb nxt_arm_cnt = ctl_rdata[B_ARM] ? arm_cnt_ff + 8'h01 : 8'h00;
	always_ff @(posedge aclk) arm_cnt_ff <= aresetn ? nxt_arm_cnt : 8'h00;
	a_load_answer: assert property (lpm_valid |-> $past(lpm)) else $error("byte without load");
	a_load_disarm: assert property (lpm |-> ##[1:2] !ctl_rdata[B_ARM]) else $error("arm after load");
	a_arm_bound: assert property (arm_cnt_ff <= PROG_CYCLES + 8) else $error("arm held too long");
	a_window_end: assert property (ctl_wr && !ee_busy && ctl_wdata[4:0] == CMD_FILL ##1 !spm [*5]
		|-> ##[0:2] !ctl_rdata[B_ARM]) else $error("window kept open");
	a_halt_page: assert property ($rose(cpu_halt) |-> zptr[13:7] >= NON_READABLE_REGION_PAGE) else $error("bad halt");
	a_write_halt: assert property (spm && ctl_rdata[B_ARM] && ctl_wdata[4:0] == CMD_WRITE && zptr[6:0] == 7'h00
		&& zptr[13:7] >= NON_READABLE_REGION_PAGE |-> ##[1:3] cpu_halt) else $error("no halt");
	a_busy_set: assert property (spm && ctl_rdata[B_ARM] && ctl_wdata[4:0] == CMD_ERASE
		|-> ##[1:3] ctl_rdata[B_BUSY]) else $error("busy not set");
	a_lock_free: assert property (spm && ctl_rdata[B_ARM] && ctl_wdata[4:0] == CMD_LOCK
		|=> !cpu_halt [*8]) else $error("halt on lock");
	c_lock_read: cover property (lpm_valid && zptr == Z_LOCK);
	c_halted: cover property ($rose(cpu_halt));
	c_window: cover property (ctl_wr ##1 !spm [*5]);
endmodule : fsp_checker

// ===== testbench/fsp_tb_top.sv
// bench: host end and sequencer joined, commands sent over AXI4-Lite
// assumes a short operation length
`timescale 1ns/10ps
module fsp_tb_top
	import fsp_pkg::*;
;
	// ----------------
	// signals and ends
	// ----------------
	localparam int unsigned PC = 20; // short operation
	logic        aclk = 1'h0, aresetn = 1'h0, por_n = 1'h0, ee = 1'h0;
	logic        awv = 1'h0, wv = 1'h0, arv = 1'h0;
	logic [3:0]  awa = 4'h0, ara = 4'h0;
	logic [31:0] wd = 32'h0, rdat, s;
	logic [5:0]  bidx = 6'h00, lockb, elock, d6;
	logic [6:0]  fpg, spg, pg;
	logic [15:0] bword;
	logic [15:0] ebuf [64];
	logic [7:0]  fuse [3];
	logic [63:0] ld;
	logic [1:0]  bresp, rresp, rsp;
	logic        awr, wr_, bv, arr, rv, fst, fer, ser, rblk, irq;
	int          bad_count = 0, checks = 0, starts = 0, n0;
	integer      seed = 32'h815bed08;
	fsp_if lnk ();
	fsp_device #(.PROG_CYCLES(PC)) fsp_device_inst (.aclk(aclk), .aresetn(aresetn), .por_n(por_n), .cpu(lnk.dev),
		.fuse_low_byte(fuse[0]), .fuse_high_byte(fuse[1]), .extended_fuse_byte(fuse[2]), .eeprom_write_busy(ee),
		.buf_rd_idx(bidx), .buf_rd_word(bword), .flash_start(fst), .flash_erase(fer), .flash_page(fpg),
		.rww_read_block(rblk), .selfprog_irq(irq), .lock_bits(lockb));
	fsp_host fsp_host_inst (.aclk(aclk), .aresetn(aresetn), .dev(lnk.cpu), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
		.s_axi_bvalid(bv), .s_axi_bready(1'h1), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(1'h1), .s_axi_rdata(rdat), .s_axi_rresp(rresp));
	fsp_checker #(.PROG_CYCLES(PC)) fsp_checker_inst (.aclk(aclk), .aresetn(aresetn), .ctl_wr(lnk.ctl_wr),
		.ctl_wdata(lnk.ctl_wdata), .ctl_rdata(lnk.ctl_rdata), .spm(lnk.spm), .lpm(lnk.lpm), .zptr(lnk.zptr),
		.lpm_valid(lnk.lpm_valid), .ee_busy(lnk.ee_busy), .cpu_halt(lnk.cpu_halt));
	always #5 aclk = ~aclk;
	// counts flash operation starts
	always @(posedge aclk)
		if (fst === 1'h1)
			{spg, ser, starts} = {fpg, fer, starts + 1};
	// ----------------
	// tasks and models
	// ----------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
		checks++;
		if (v !== e)
		begin
			$display("ERROR %s exp %h got %h", n, e, v);
			bad_count++;
		end
	endtask : chk
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	task automatic hang;
		chk("wait", 32'h1, 32'h0);
		test_done;
	endtask : hang
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		awa <= a;
		wd <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		for (int n = 0; n < 200 && (n == 0 || !bv); n++)
		begin
			@(posedge aclk);
			if (awv && awr) awv <= 1'h0;
			if (wv && wr_) wv <= 1'h0;
		end
		if (!bv) hang;
		chk("bresp", RESP_OKAY, bresp);
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		ara <= a;
		arv <= 1'h1;
		for (int n = 0; n < 200 && (n == 0 || !rv); n++)
		begin
			@(posedge aclk);
			if (arv && arr) arv <= 1'h0;
		end
		if (!rv) hang;
		d = rdat;
		rsp = rresp;
	endtask : rd
	task automatic cmd(input logic [7:0] v, input logic [1:0] f);
		wr(REG_CMD, {22'h0, f, v});
		for (int n = 0; n < 60 && (n == 0 || s[16] || s[17] || s[B_ARM]); n++) rd(REG_STAT, s);
		if (s[16] || s[17] || s[B_ARM]) hang;
	endtask : cmd
	task automatic fill(input logic [5:0] x, input logic [15:0] w);
		wr(REG_ZPTR, {25'h0, x, 1'h0});
		wr(REG_DATA, {16'h0, w});
		cmd({3'h0, CMD_FILL}, FOLLOW_SPM);
		if (!ld[x]) ebuf[x] = w;
		ld[x] = 1'h1;
		bidx <= x;
		repeat (2) @(posedge aclk);
		chk("buf_word", ebuf[x], bword);
	endtask : fill
	task automatic clr;
		ld = '0;
		for (int i = 0; i < 64; i++) ebuf[i] = ERASED_WORD;
	endtask : clr
	function automatic logic [7:0] exp_byte(input logic [15:0] z);
		case (z)
			Z_FUSE_LOW: return fuse[0];
			Z_FUSE_HIGH: return fuse[1];
			Z_FUSE_EXT: return fuse[2];
			Z_LOCK: return {LOCK_PAD, elock};
			default: return NO_BYTE;
		endcase
	endfunction : exp_byte
	// main sequence
	initial
	begin
		for (int i = 0; i < 3; i++) fuse[i] = 8'($random(seed));
		clr;
		elock = LOCK_ERASED;
		d6 = 6'($random(seed));
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		por_n <= 1'h1;
		@(posedge aclk);
		chk("lock_bits", LOCK_ERASED, lockb);
		wr(REG_DATA, {24'h0, 2'h3, d6});
		wr(REG_ZPTR, 32'(Z_LOCK));
		cmd({3'h0, CMD_LOCK}, FOLLOW_SPM);
		elock = elock & d6;
		chk("lock_bits", elock, lockb);
		for (int z = 0; z < 5; z++)
		begin
			wr(REG_ZPTR, 32'(z));
			cmd({3'h0, CMD_LOCK}, FOLLOW_LPM);
			rd(REG_STAT, s);
			chk("rd_byte", exp_byte(16'(z)), s[15:8]);
		end
		rd(4'h2, s);
		chk("rresp", RESP_SLVERR, rsp);
		$display("test lock and fuse done");
		for (int i = 0; i < 4; i++) fill((i % 3 == 0) ? 6'h00 : (i == 1 ? 6'h3F : 6'($random(seed))), 16'($random(seed)));
		cmd({3'h0, CMD_FILL}, 2'h0);
		chk("buf_word", ebuf[bidx], bword);
		for (int k = 0; k < 3; k++)
		begin
			n0 = starts;
			pg = (k == 1) ? NON_READABLE_REGION_PAGE : 7'($random(seed));
			wr(REG_ZPTR, {18'h0, pg, (k == 0) ? 7'h15 : 7'(k / 2)});
			cmd({3'h0, (k == 0) ? CMD_ERASE : CMD_WRITE}, FOLLOW_SPM);
			chk("starts", n0 + (k < 2), starts);
			if (k < 2) chk("op", {k == 0, pg}, {ser, spg});
		end
		chk("buf_clear", ERASED_WORD, bword);
		chk("rd_block", 1'h1, rblk);
		clr;
		fill(6'h05, 16'($random(seed)));
		cmd({3'h0, CMD_REEN}, FOLLOW_SPM);
		chk("buf_clear", ERASED_WORD, bword);
		rd(REG_STAT, s);
		chk("busy_flag", 1'h0, s[B_BUSY]);
		fill(6'h07, 16'($random(seed)));
		ee <= 1'h1;
		repeat (3) @(posedge aclk);
		ee <= 1'h0;
		@(posedge aclk);
		chk("buf_clear", ERASED_WORD, bword);
		cmd(8'h80, 2'h0);
		chk("irq", 1'h1, irq);
		$display("test buffer and pages done");
		wr(REG_ZPTR, {18'h0, NON_READABLE_REGION_PAGE, 7'h00});
		wr(REG_CMD, {22'h0, FOLLOW_SPM, 3'h4, CMD_WRITE});
		for (n0 = 0; fst !== 1'h1 && n0 < 20; n0++) @(posedge aclk);
		chk("irq", 1'h0, irq);
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
		chk("halt", 1'h1, lnk.cpu_halt);
		for (n0 = 0; lnk.cpu_halt !== 1'h0 && n0 < 40; n0++) @(posedge aclk);
		chk("halt", 1'h0, lnk.cpu_halt);
		$display("test reset in operation done");
		test_done;
	end
endmodule : fsp_tb_top
